// ==== design/mode0_regulator_cfg.sv ====
`timescale 1ns/1ps
module mode0_regulator_cfg #(
    parameter int FILTER_LEN = mode0_cfg_pkg::FILTER_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Nonvolatile defaults, sampled on reset release
    input wire mode0_cfg_pkg::nv_defaults_s nv_defaults_i,
    // Register port from the serial target
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Mode state
    input wire logic in_mode0_i,
    input wire logic button_n_i,
    output logic mode0_return_o,
    // Regulator controls
    output mode0_cfg_pkg::enables_s enables_o,
    output logic [11:0] system_buck_mv_o,
    output logic [11:0] aon_regulator_mv_o
);
    // ==========================================================
    // Registers
    logic rsvd_ff;
    logic return_hold_ff;
    logic system_buck_offset_sel_ff;
    logic [4:0] system_buck_voltage_code_ff;
    logic [3:0] aon_regulator_voltage_code_ff;
    mode0_cfg_pkg::enables_s enables_ff;
    logic nv_loaded_ff;
    logic btn_meta_ff;
    logic btn_sync_ff;
    logic btn_stable_ff;
    logic [$clog2(FILTER_LEN+1)-1:0] filt_cnt_ff;
    logic mode0_return_ff;

    function automatic logic [11:0] code_to_mv(input logic [11:0] base,
                                                input logic [4:0] code,
                                                input logic [4:0] cmax);
        logic [4:0] c;
        c = (code > cmax) ? cmax : code;
        code_to_mv = base + 12'(c) * mode0_cfg_pkg::STEP_MV;
    endfunction : code_to_mv

    // ==========================================================
    // Decode
    wire wr_first = reg_wr_i && (reg_addr_i == mode0_cfg_pkg::ADDR_BUTTON_BUCK);
    wire wr_second = reg_wr_i && (reg_addr_i == mode0_cfg_pkg::ADDR_AON_ENABLES);
    wire [7:0] first_rd = {rsvd_ff, return_hold_ff, system_buck_offset_sel_ff,
                           system_buck_voltage_code_ff};
    wire [7:0] second_rd = {aon_regulator_voltage_code_ff, enables_ff};
    // Filter qualifies a fall once the synced low has held FILTER_LEN cycles
    wire filt_done = (filt_cnt_ff == ($clog2(FILTER_LEN+1))'(FILTER_LEN));
    wire valid_fall = btn_stable_ff && !btn_sync_ff && filt_done;
    wire nxt_return = valid_fall && !return_hold_ff && !in_mode0_i;

    assign reg_rdata_o = (reg_addr_i == mode0_cfg_pkg::ADDR_BUTTON_BUCK) ? first_rd :
                         (reg_addr_i == mode0_cfg_pkg::ADDR_AON_ENABLES) ? second_rd :
                         8'h00;
    assign enables_o = enables_ff;
    assign mode0_return_o = mode0_return_ff;
    assign system_buck_mv_o = code_to_mv(mode0_cfg_pkg::BUCK_BASE_MV,
        system_buck_voltage_code_ff, mode0_cfg_pkg::BUCK_CODE_MAX) +
        (system_buck_offset_sel_ff ? mode0_cfg_pkg::OFFSET_MV : 12'h0000);
    assign aon_regulator_mv_o = code_to_mv(mode0_cfg_pkg::AON_BASE_MV,
        {1'b0, aon_regulator_voltage_code_ff},
        {1'b0, mode0_cfg_pkg::AON_CODE_MAX});

    // ==========================================================
    // First register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsvd_ff <= 1'b0;
            return_hold_ff <= 1'b0;
            system_buck_offset_sel_ff <= 1'b0;
            system_buck_voltage_code_ff <= mode0_cfg_pkg::BUCK_CODE_RST;
        end else if (!nv_loaded_ff) begin
            system_buck_voltage_code_ff <= nv_defaults_i.system_buck_voltage_code;
        end else if (wr_first) begin
            rsvd_ff <= reg_wdata_i[mode0_cfg_pkg::RSVD_BIT];
            return_hold_ff <= reg_wdata_i[mode0_cfg_pkg::RETURN_BIT];
            system_buck_offset_sel_ff <= reg_wdata_i[mode0_cfg_pkg::OFFSET_BIT];
            system_buck_voltage_code_ff <= reg_wdata_i[4:0];
        end
    end

    // ==========================================================
    // Second register; defaults are caught one cycle after release
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nv_loaded_ff <= 1'b0;
            aon_regulator_voltage_code_ff <= mode0_cfg_pkg::AON_CODE_RST;
            enables_ff <= mode0_cfg_pkg::ENABLES_RST;
        end else if (!nv_loaded_ff) begin
            nv_loaded_ff <= 1'b1;
            aon_regulator_voltage_code_ff <= nv_defaults_i.aon_regulator_voltage_code;
            enables_ff <= nv_defaults_i.enables;
        end else if (wr_second) begin
            aon_regulator_voltage_code_ff <= reg_wdata_i[7:mode0_cfg_pkg::AON_CODE_LSB];
            enables_ff <= reg_wdata_i[mode0_cfg_pkg::CORE_EN_BIT:0];
        end
    end

    // ==========================================================
    // Button synchroniser and filter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            btn_meta_ff <= 1'b1;
            btn_sync_ff <= 1'b1;
            btn_stable_ff <= 1'b1;
            filt_cnt_ff <= '0;
            mode0_return_ff <= 1'b0;
        end else begin
            btn_meta_ff <= button_n_i;
            btn_sync_ff <= btn_meta_ff;
            mode0_return_ff <= nxt_return;
            if (btn_sync_ff == btn_stable_ff) begin
                filt_cnt_ff <= '0;
            end else if (filt_done) begin
                btn_stable_ff <= btn_sync_ff;
                filt_cnt_ff <= '0;
            end else begin
                filt_cnt_ff <= filt_cnt_ff + 1'b1;
            end
        end
    end
endmodule : mode0_regulator_cfg

// ==== design/mode0_cfg_pkg.sv ====
// Functional notes
// - Return bit 0 plus valid button fall requests mode 0 unless already there.
// - Return bit 1: button fall causes no mode change.
// - Offset bit adds 1.2 V to the system buck code voltage.
// - Buck code 00000 is 1.500 V, 25 mV steps, codes from 11000 clamp 2.100 V.
// - Buck code resets to 01100 (1.800 V), loadable from nonvolatile cells.
// - Always-on code 0000 is 1.700 V, 25 mV steps, codes from 1000 clamp 1.900 V.
// - Always-on code resets to 0100 (1.800 V), loadable from nonvolatile cells.
// - Bit 3 of second register enables core buck, reset 1.
// - Bit 2 of second register enables system buck, reset 1.
// - Bit 1 of second register enables always-on regulator, reset 1.
// - Bit 0 of second register enables system regulator, reset 1.
// - Each enable's reset value comes from its own one-bit nonvolatile cell.
// - Both registers fully read/write; bit 7 of first is reserved, reset 0.
package mode0_cfg_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_BUTTON_BUCK = 8'h23;
    localparam logic [7:0] ADDR_AON_ENABLES = 8'h24;
    // Field positions, first register
    localparam int RSVD_BIT = 7;
    localparam int RETURN_BIT = 6;
    localparam int OFFSET_BIT = 5;
    // Field positions, second register
    localparam int AON_CODE_LSB = 4;
    localparam int CORE_EN_BIT = 3;
    localparam int SYS_BUCK_EN_BIT = 2;
    localparam int AON_EN_BIT = 1;
    localparam int SYS_REG_EN_BIT = 0;
    // ==========================================================
    // Reset values
    localparam logic [4:0] BUCK_CODE_RST = 5'h0c;
    localparam logic [3:0] AON_CODE_RST = 4'h4;
    localparam logic [3:0] ENABLES_RST = 4'hf;
    // ==========================================================
    // Voltage arithmetic, millivolts
    localparam logic [11:0] BUCK_BASE_MV = 12'h05dc;
    localparam logic [11:0] AON_BASE_MV = 12'h06a4;
    localparam logic [11:0] STEP_MV = 12'h0019;
    localparam logic [11:0] OFFSET_MV = 12'h04b0;
    localparam logic [4:0] BUCK_CODE_MAX = 5'h18;
    localparam logic [3:0] AON_CODE_MAX = 4'h8;
    // Button filter length, cycles
    localparam int FILTER_CYCLES = 4;

    typedef struct packed {
        logic core_buck_enable;
        logic system_buck_enable;
        logic aon_regulator_enable;
        logic system_regulator_enable;
    } enables_s;

    typedef struct packed {
        logic [4:0] system_buck_voltage_code;
        logic [3:0] aon_regulator_voltage_code;
        enables_s enables;
    } nv_defaults_s;
endpackage : mode0_cfg_pkg

// ==== bench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
    // Bus side
    input wire logic clk_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o
);
    initial {reg_addr_o, reg_wr_o, reg_wdata_o} = 17'h0_0000;
    // Idle data toggles so stale bytes never look valid
    task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = w ? d : ~reg_wdata_o;
        reg_wr_o = w;
    endtask : put
endmodule : host_model

// ==== bench/mode0_regulator_cfg_chk.sv ====
`timescale 1ns/1ps
module mode0_regulator_cfg_chk #(parameter int FILTER_LEN = 4) (
    // Watched ports
    input wire logic clk_i, resetn_i, reg_wr_i, in_mode0_i, button_n_i, mode0_return_o,
    input wire mode0_cfg_pkg::nv_defaults_s nv_defaults_i,
    input wire mode0_cfg_pkg::enables_s enables_o,
    input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
    input wire logic [11:0] system_buck_mv_o, aon_regulator_mv_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic sel_a = reg_addr_i == 8'h23;
    wire logic sel_b = reg_addr_i == 8'h24;
    wire logic [4:0] bc = reg_rdata_o[4:0] > 5'h18 ? 5'h18 : reg_rdata_o[4:0];
    wire logic [3:0] ac = reg_rdata_o[7:4] > 4'h8 ? 4'h8 : reg_rdata_o[7:4];
    sequence s_released;
        !$past(resetn_i) ##0 resetn_i;
    endsequence
    // First edge after release is the load edge, so writes there are lost
    sequence s_wr_taken;
        reg_wr_i && (sel_a || sel_b) && $past(resetn_i) ##1 $stable(reg_addr_i);
    endsequence
    a_nv_enable_load: assert property (s_released |=>
        enables_o == $past(nv_defaults_i.enables)) else $error("enables not loaded");
    a_write_lands: assert property (s_wr_taken |->
        reg_rdata_o == $past(reg_wdata_i)) else $error("write not visible");
    a_unmapped_zero: assert property (!(sel_a || sel_b) |->
        reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_buck_mv_map: assert property (sel_a |-> system_buck_mv_o ==
        12'h05dc + 12'h0019 * bc + (reg_rdata_o[5] ? 12'h04b0 : 12'h0000)) else $error("buck mv");
    a_aon_mv_map: assert property (sel_b |->
        aon_regulator_mv_o == 12'h06a4 + 12'h0019 * ac) else $error("aon mv");
    a_enables_match: assert property (sel_b |->
        enables_o == reg_rdata_o[3:0]) else $error("enables differ from register");
    a_return_single: assert property (mode0_return_o |=>
        !mode0_return_o) else $error("return request longer than one cycle");
    a_return_cause: assert property (mode0_return_o |-> !$past(in_mode0_i) &&
        !$past(button_n_i) && !$past(button_n_i, 3)) else $error("return without cause");
endmodule : mode0_regulator_cfg_chk
bind mode0_regulator_cfg mode0_regulator_cfg_chk #(.FILTER_LEN(FILTER_LEN)) chk_u (
    .clk_i, .resetn_i, .reg_wr_i, .in_mode0_i, .button_n_i, .mode0_return_o, .nv_defaults_i,
    .enables_o, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .system_buck_mv_o, .aon_regulator_mv_o);

// ==== bench/tb_pmic_mode0_regulator_cfg.sv ====
`timescale 1ns/1ps
module tb_pmic_mode0_regulator_cfg;
    logic clk_i = 1'b0, resetn_i = 1'b0, in_mode0_i = 1'b0, button_n_i = 1'b1, wr, ret;
    logic [7:0] addr, wdata, rdata;
    logic [11:0] buck_mv, aon_mv;
    logic [31:0] seed = 32'h89c1_f64e, r;
    mode0_cfg_pkg::nv_defaults_s nv = 13'h0000;
    mode0_cfg_pkg::enables_s en;
    int n_errors = 0, checked = 0;
    always #5 clk_i = ~clk_i;
    host_model host_u (.clk_i, .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata));
    mode0_regulator_cfg #(.FILTER_LEN(1)) dut_u (.clk_i, .resetn_i, .nv_defaults_i(nv),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .in_mode0_i, .button_n_i, .mode0_return_o(ret), .enables_o(en),
        .system_buck_mv_o(buck_mv), .aon_regulator_mv_o(aon_mv));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [11:0] mv(input logic [11:0] b, input logic [4:0] c, m, input logic o);
        return b + 12'h0019 * (c > m ? m : c) + (o ? 12'h04b0 : 12'h0000);
    endfunction : mv
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        if (n_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic press(input logic want);
        logic seen;
        seen = 1'b0;
        button_n_i = 1'b0;
        repeat (12) @(negedge clk_i) seen |= ret;
        button_n_i = 1'b1;
        repeat (6) @(negedge clk_i);
        check(seen, want);
    endtask : press
    initial begin
        r = rnd();
        nv = r[12:0];
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        host_u.put(8'h24, 8'h00, 1'b0);
        #1 check(rdata, nv[7:0]);
        host_u.put(8'h23, 8'h00, 1'b0);
        #1 check(rdata, nv[12:8]);
        // Two clamp corners first, then random bytes over mapped and unmapped places
        for (int i = 0; i < 60; i++) begin
            r = (i == 0) ? 32'h0000_00ff : (i == 1) ? 32'h0000_0190 : rnd();
            host_u.put(8'h23 + r[9:8], r[7:0], 1'b1);
            host_u.put(8'h23 + r[9:8], r[7:0], 1'b0);
            #1 check(rdata, r[9] ? 8'h00 : r[7:0]);
            if (r[9:8] == 2'b00) check(buck_mv, mv(12'h05dc, r[4:0], 5'h18, r[5]));
            if (r[9:8] == 2'b01) check(aon_mv, mv(12'h06a4, r[7:4], 5'h08, 1'b0));
            if (r[9:8] == 2'b01) check(en, r[3:0]);
        end
        host_u.put(8'h23, 8'h40, 1'b1);
        host_u.put(8'h23, 8'h40, 1'b0);
        press(1'b0);
        host_u.put(8'h23, 8'h00, 1'b1);
        host_u.put(8'h23, 8'h00, 1'b0);
        in_mode0_i = 1'b1;
        press(1'b0);
        in_mode0_i = 1'b0;
        press(1'b1);
        conclude();
    end
endmodule : tb_pmic_mode0_regulator_cfg
